/* hw/spcfg_map.svh */
// Offsets, field positions, reset values and timing counts of the serial port block.
// Assumes nothing; definitions only.
`ifndef SPCFG_MAP_SVH
`define SPCFG_MAP_SVH
`define SPCFG_CFG_ADDR    15'h0000
`define SPCFG_CFG_RESET   16'h0000
`define SPCFG_PAT_LO      15'h6000
`define SPCFG_PAT_HI      15'h6FFF
`define SPCFG_B_LSBF      15
`define SPCFG_B_3WIRE     14
`define SPCFG_B_SWRST     13
`define SPCFG_B_DUAL      12
`define SPCFG_B_DRV       11
`define SPCFG_B_AUX       10
`define SPCFG_M_SWRST     2
`define SPCFG_CLK_NS      25
`define SPCFG_SWRST_NS    1000
`define SPCFG_SWRST_CYC   ((`SPCFG_SWRST_NS + `SPCFG_CLK_NS - 1) / `SPCFG_CLK_NS)
`endif

/* hw/spcfg_pinsync.sv */
// Two-stage synchronisers for the serial pins and serial clock edge detection.
// Assumes pins are asynchronous to clk and the serial clock is far slower than clk.
`timescale 1ns/100ps
`default_nettype none
module spcfg_pinsync (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   sclk,
    input  wire logic   cs_n,
    input  wire logic   sdio_i,
    input  wire logic   sdo_i,
    spcfg_sync_if.src   sy
);
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic       sclk_d_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r     <= 4'h1;
            s2_r     <= 4'h1;
            sclk_d_r <= 1'b0;
        end else begin
            s1_r     <= {sdo_i, sdio_i, sclk, cs_n};
            s2_r     <= s1_r;
            sclk_d_r <= s2_r[1];
        end
    end

    assign sy.cs_act    = ~s2_r[0];
    assign sy.sclk_rise = s2_r[1] & ~sclk_d_r;
    assign sy.sclk_fall = ~s2_r[1] & sclk_d_r;
    assign sy.d0        = s2_r[2];
    assign sy.d1        = s2_r[3];
endmodule : spcfg_pinsync
`default_nettype wire

/* hw/spcfg_pkg.sv */
// Types shared by the serial port configuration block.
// Assumes spcfg_map.svh carries the numeric constants.
package spcfg_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b10,
        ST_DONE  = 2'b11
    } spcfg_state_t;
endpackage : spcfg_pkg

/* hw/spcfg_sync_if.sv */
// Synchronised serial pin view passed from the pin sampler to the port logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface spcfg_sync_if;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_act;
    logic d0;
    logic d1;
    modport src (output sclk_rise, output sclk_fall, output cs_act, output d0, output d1);
    modport dst (input sclk_rise, input sclk_fall, input cs_act, input d0, input d1);
endinterface : spcfg_sync_if
`default_nettype wire

/* hw/spcfg_top.sv */
// Serial port with its own configuration register at address zero.
// Assumes pins arrive asynchronously; other registers and pattern memory sit on ext_*.
// Function
// - Words shift MSB first when bit order select is 0, LSB first when 1.
// - Three-wire select 0 gives 4-wire port, 1 gives shared single data line.
// - Software reset resets port and map, keeps the address-zero register but clears its two reset bits.
// - Dual select gives two bidirectional data lines sharing chip select and clock.
// - Dual mode serves only pattern memory transfers; others use one line.
// - Drive select 0 asks single output drive, 1 asks doubled drive.
// - Pin select 0: shared pin is data out or line two; 1: auxiliary output.
`timescale 1ns/100ps
`default_nettype none
`include "spcfg_map.svh"
module spcfg_top
    import spcfg_pkg::*;
#(
    parameter int SWRST_CYC = `SPCFG_SWRST_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdio_i,
    output logic             sdio_o,
    output logic             sdio_oe,
    input  wire logic        sdo_i,
    output logic             sdo_o,
    output logic             sdo_oe,
    input  wire logic        aux_dout,
    output logic             bit_order_select,
    output logic             three_wire_select,
    output logic             dual_data_line_select,
    output logic             output_drive_double,
    output logic             aux_output_select,
    output logic             map_reset,
    output logic [14:0]      ext_addr,
    output logic [15:0]      ext_wdata,
    output logic             ext_we,
    output logic             ext_rd,
    input  wire logic [15:0] ext_rdata
);
    if (SWRST_CYC < 1 || SWRST_CYC > 65535) begin : g_bad_swrst
        $error("SWRST_CYC out of range");
    end

    function automatic logic [5:0] spcfg_rev6(input logic [5:0] v);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < 6; i++) r[i] = v[5 - i];
        return r;
    endfunction : spcfg_rev6

    function automatic logic [15:0] spcfg_sh16(input logic [15:0] s, input logic b,
                                               input logic lsb);
        return lsb ? {b, s[15:1]} : {s[14:0], b};
    endfunction : spcfg_sh16

    function automatic logic [7:0] spcfg_sh8(input logic [7:0] s, input logic b,
                                             input logic lsb);
        return lsb ? {b, s[7:1]} : {s[6:0], b};
    endfunction : spcfg_sh8

    spcfg_sync_if sy ();
    spcfg_pinsync u_sync (
        .clk    (clk),
        .rst    (rst),
        .sclk   (sclk),
        .cs_n   (cs_n),
        .sdio_i (sdio_i),
        .sdo_i  (sdo_i),
        .sy     (sy)
    );

    spcfg_state_t state_r;
    logic [15:0]  cfg_r;
    logic [15:10] eff;
    logic [15:0]  sr_r;
    logic [15:0]  rx_nxt;
    logic [15:0]  tx_r;
    logic [4:0]   cnt_r;
    logic [3:0]   bidx;
    logic         rw_r;
    logic [14:0]  addr_r;
    logic         dual_r;
    logic         last_bit;
    logic         instr_done;
    logic         data_done;
    logic         wr_cfg;
    logic         rd_cap_r;
    logic         rd_cap2_r;
    logic         out0_r;
    logic         out1_r;
    logic         aux_q_r;
    logic         drive_phase;
    logic [15:0]  swrst_cnt_r;

    // Either copy sets a field, so a host using the wrong bit order still gets through
    assign eff = cfg_r[15:10] | spcfg_rev6(cfg_r[5:0]);
    assign bit_order_select      = eff[`SPCFG_B_LSBF];
    assign three_wire_select     = eff[`SPCFG_B_3WIRE];
    assign dual_data_line_select = eff[`SPCFG_B_DUAL];
    assign output_drive_double   = eff[`SPCFG_B_DRV];
    assign aux_output_select     = eff[`SPCFG_B_AUX];

    always_comb begin
        if (state_r == ST_DATA && dual_r) begin
            rx_nxt = {spcfg_sh8(sr_r[15:8], sy.d0, eff[`SPCFG_B_LSBF]),
                      spcfg_sh8(sr_r[7:0], sy.d1, eff[`SPCFG_B_LSBF])};
        end else begin
            rx_nxt = spcfg_sh16(sr_r, sy.d0, eff[`SPCFG_B_LSBF]);
        end
    end

    assign last_bit   = (state_r == ST_DATA && dual_r) ? (cnt_r == 5'd7) : (cnt_r == 5'd15);
    assign instr_done = sy.sclk_rise && sy.cs_act && state_r == ST_INSTR && last_bit;
    assign data_done  = sy.sclk_rise && sy.cs_act && state_r == ST_DATA && last_bit;
    assign wr_cfg     = data_done && !rw_r && addr_r == `SPCFG_CFG_ADDR;

    always_ff @(posedge clk) begin
        if (rst || map_reset) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else if (!sy.cs_act) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    state_r <= ST_INSTR;
                    cnt_r   <= '0;
                end
                ST_INSTR, ST_DATA: begin
                    if (sy.sclk_rise) begin
                        cnt_r <= last_bit ? 5'd0 : cnt_r + 5'd1;
                        if (last_bit) state_r <= (state_r == ST_INSTR) ? ST_DATA : ST_DONE;
                    end
                end
                ST_DONE: state_r <= ST_DONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sr_r   <= '0;
            rw_r   <= 1'b0;
            addr_r <= '0;
            dual_r <= 1'b0;
        end else if (sy.sclk_rise && sy.cs_act &&
                     (state_r == ST_INSTR || state_r == ST_DATA)) begin
            sr_r <= rx_nxt;
            if (instr_done) begin
                rw_r   <= rx_nxt[15];
                addr_r <= rx_nxt[14:0];
                // Dual lines only for pattern memory and only with the pin free
                dual_r <= eff[`SPCFG_B_DUAL] && !eff[`SPCFG_B_AUX] &&
                          rx_nxt[14:0] >= `SPCFG_PAT_LO &&
                          rx_nxt[14:0] <= `SPCFG_PAT_HI;
            end
        end
    end

    // Configuration register survives the map reset; only its reset pair self-clears
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= `SPCFG_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= rx_nxt;
        end else if (map_reset && swrst_cnt_r == 16'h0001) begin
            cfg_r[`SPCFG_B_SWRST] <= 1'b0;
            cfg_r[`SPCFG_M_SWRST] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            map_reset   <= 1'b0;
            swrst_cnt_r <= '0;
        end else if (wr_cfg && (rx_nxt[`SPCFG_B_SWRST] || rx_nxt[`SPCFG_M_SWRST])) begin
            map_reset   <= 1'b1;
            swrst_cnt_r <= 16'(SWRST_CYC);
        end else if (map_reset) begin
            swrst_cnt_r <= swrst_cnt_r - 16'h0001;
            if (swrst_cnt_r == 16'h0001) map_reset <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_addr  <= '0;
            ext_wdata <= '0;
            ext_we    <= 1'b0;
            ext_rd    <= 1'b0;
            rd_cap_r  <= 1'b0;
            rd_cap2_r <= 1'b0;
        end else begin
            ext_we    <= data_done && !rw_r && addr_r != `SPCFG_CFG_ADDR;
            ext_rd    <= instr_done && rx_nxt[15] && rx_nxt[14:0] != `SPCFG_CFG_ADDR;
            rd_cap_r  <= instr_done && rx_nxt[15];
            rd_cap2_r <= rd_cap_r;
            if (instr_done) ext_addr <= rx_nxt[14:0];
            if (data_done) ext_wdata <= rx_nxt;
        end
    end

    // Read data is taken one cycle after the strobe, well before the first falling edge
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_r <= '0;
        end else if (rd_cap2_r) begin
            tx_r <= (addr_r == `SPCFG_CFG_ADDR) ? cfg_r : ext_rdata;
        end
    end

    assign bidx = eff[`SPCFG_B_LSBF] ? cnt_r[3:0] :
                  (dual_r ? 4'h7 - cnt_r[3:0] : 4'hF - cnt_r[3:0]);

    always_ff @(posedge clk) begin
        if (rst) begin
            out0_r  <= 1'b0;
            out1_r  <= 1'b0;
            aux_q_r <= 1'b0;
        end else begin
            aux_q_r <= aux_dout;
            if (sy.sclk_fall && state_r == ST_DATA) begin
                out0_r <= dual_r ? tx_r[{1'b1, bidx[2:0]}] : tx_r[bidx];
                out1_r <= tx_r[{1'b0, bidx[2:0]}];
            end
        end
    end

    // Last read bit stands until chip select rises, past the host's final sample
    assign drive_phase = (state_r == ST_DATA || state_r == ST_DONE) && rw_r && sy.cs_act;
    assign sdio_o      = out0_r;
    assign sdio_oe     = drive_phase && (eff[`SPCFG_B_3WIRE] || dual_r);
    assign sdo_o       = eff[`SPCFG_B_AUX] ? aux_q_r : (dual_r ? out1_r : out0_r);
    assign sdo_oe      = eff[`SPCFG_B_AUX] ||
                         (drive_phase && (dual_r || !eff[`SPCFG_B_3WIRE]));

    AST_BIT_ORDER: assert property (@(posedge clk) disable iff (rst)
        sy.sclk_fall && state_r == ST_DATA && !dual_r && cnt_r == 5'd0 && !rd_cap2_r
        |=> out0_r == (bit_order_select ? tx_r[0] : tx_r[15]))
        else $error("first data bit does not follow bit order");
    AST_WIRE_MODE: assert property (@(posedge clk) disable iff (rst)
        drive_phase && !dual_r && !aux_output_select
        |-> sdio_oe == three_wire_select && sdo_oe == !three_wire_select)
        else $error("read data on wrong line for wire mode");
    logic [16:0]  mr_len_r;
    // Pulse length counted here so no long delay range is needed
    always_ff @(posedge clk) begin
        if (rst || !map_reset) begin
            mr_len_r <= '0;
        end else begin
            mr_len_r <= mr_len_r + 17'd1;
        end
    end

    AST_SWRST_PORT: assert property (@(posedge clk) disable iff (rst)
        $fell(map_reset) |-> mr_len_r == 17'(SWRST_CYC))
        else $error("map reset pulse length wrong");
    AST_SWRST_KEEP: assert property (@(posedge clk) disable iff (rst)
        map_reset |=> state_r == ST_IDLE && $stable(cfg_r[15:14]))
        else $error("port active or config lost during map reset");
    AST_DUAL_LINES: assert property (@(posedge clk) disable iff (rst)
        drive_phase && dual_r |-> sdio_oe && sdo_oe)
        else $error("dual read does not drive both lines");
    AST_DUAL_PATTERN: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_DATA && dual_r |-> addr_r >= `SPCFG_PAT_LO && addr_r <= `SPCFG_PAT_HI)
        else $error("dual transfer outside pattern memory");
    AST_DRIVE_CAUSE: assert property (@(posedge clk) disable iff (rst)
        $rose(output_drive_double) |-> $past(wr_cfg))
        else $error("drive select changed without a config write");
    AST_AUX_PIN: assert property (@(posedge clk) disable iff (rst)
        aux_output_select && $stable(aux_output_select) && !wr_cfg
        |=> sdo_oe && sdo_o == $past(aux_dout))
        else $error("aux output not on shared pin");
    AST_MIRROR: assert property (@(posedge clk) disable iff (rst)
        cfg_r[0] && !cfg_r[15] |-> bit_order_select)
        else $error("mirror copy of bit order ignored");
    AST_SWRST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        $fell(map_reset) |-> !cfg_r[`SPCFG_B_SWRST] && !cfg_r[`SPCFG_M_SWRST])
        else $error("reset bits not cleared after map reset");

    COV_CFG_WRITE: cover property (@(posedge clk) disable iff (rst) wr_cfg);
    COV_DUAL_READ: cover property (@(posedge clk) disable iff (rst) drive_phase && dual_r);
    COV_SWRST: cover property (@(posedge clk) disable iff (rst) $fell(map_reset));
    COV_LSB_READ: cover property (@(posedge clk) disable iff (rst)
        rd_cap2_r && bit_order_select);
endmodule : spcfg_top
`default_nettype wire

/* sim/spcfg_host_model.sv */
// Host serial controller model: mode 0 frames on one, three-wire or dual lines.
// Assumes the device samples on sclk rise and answers within half an sclk period.
`timescale 1ns/100ps
`default_nettype none
module spcfg_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_i,
    output logic      sdo_i,
    input  wire logic sdio_o,
    input  wire logic sdio_oe,
    input  wire logic sdo_o,
    input  wire logic sdo_oe
);
    logic hd_r;
    logic hs_r;
    // Released lines toggle so a stale bit never reads back as a match
    assign sdio_i = sdio_oe ? sdio_o : hd_r;
    assign sdo_i  = sdo_oe ? sdo_o : hs_r;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        hd_r = 1'b0;
        hs_r = 1'b0;
    end
    task automatic xfer(input logic lsb, input logic tw, input logic dl, input logic [15:0] ins,
                        input logic [15:0] wd, output logic [15:0] rd);
        int j;
        int b;
        rd = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int k = 0; k < (dl ? 24 : 32); k++) begin
            @(posedge clk);
            sclk <= 1'b0;
            j = (k < 16) ? k : k - 16;
            b = lsb ? j : ((dl && k > 15) ? 7 : 15) - j;
            if (k < 16) begin
                hd_r <= ins[b];
            end else if (ins[15]) begin
                hd_r <= ~hd_r;
                hs_r <= ~hs_r;
            end else begin
                hd_r <= dl ? wd[b + 8] : wd[b];
                hs_r <= dl ? wd[b] : ~hs_r;
            end
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            if (k > 15 && ins[15] && dl) begin
                rd[b + 8] = sdio_i;
                rd[b] = sdo_i;
            end else if (k > 15 && ins[15]) begin
                rd[b] = tw ? sdio_i : sdo_i;
            end
        end
        @(posedge clk);
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : xfer
endmodule : spcfg_host_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the serial port configuration block.
// Assumes the host model drives the pins and ext_rdata is a fixed function of ext_addr.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int SWC = 4;
    logic        clk;
    logic        rst;
    logic        sclk;
    logic        cs_n;
    logic        sdio_i;
    logic        sdio_o;
    logic        sdio_oe;
    logic        sdo_i;
    logic        sdo_o;
    logic        sdo_oe;
    logic        aux_dout;
    logic [4:0]  cfg_o;
    logic        map_reset;
    logic [14:0] ext_addr;
    logic [15:0] ext_wdata;
    logic        ext_we;
    logic        ext_rd;
    logic [15:0] ext_rdata;
    logic [14:0] wa;
    logic [15:0] wd;
    logic [15:0] v;
    logic        lsb_m;
    logic        tw_m;
    int          mr_n;
    int          rd_n;
    int          cyc;
    int          bad_count;
    int          samples_checked;

    spcfg_top #(.SWRST_CYC(SWC)) dut (
        .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
        .sdio_oe(sdio_oe), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .aux_dout(aux_dout),
        .bit_order_select(cfg_o[4]), .three_wire_select(cfg_o[3]),
        .dual_data_line_select(cfg_o[2]), .output_drive_double(cfg_o[1]),
        .aux_output_select(cfg_o[0]), .map_reset(map_reset), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_we(ext_we), .ext_rd(ext_rd), .ext_rdata(ext_rdata)
    );
    spcfg_host_model host (
        .clk(clk), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdo_i(sdo_i),
        .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe)
    );
    assign ext_rdata = {1'b0, ext_addr} ^ 16'h5A3C;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ext_we === 1'b1) begin
            wa <= ext_addr;
            wd <= ext_wdata;
        end
        if (map_reset === 1'b1) begin
            mr_n <= mr_n + 1;
        end
        if (ext_rd === 1'b1) begin
            rd_n <= rd_n + 1;
        end
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [14:0] a, input logic [15:0] d, input logic dl);
        host.xfer(lsb_m, tw_m, dl, {1'b0, a}, d, v);
    endtask : wr_reg
    task automatic rd_reg(input logic [14:0] a, input logic dl, output logic [15:0] d);
        host.xfer(lsb_m, tw_m, dl, {1'b1, a}, 16'h0000, d);
    endtask : rd_reg
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        rst = 1'b1;
        aux_dout = 1'b0;
        lsb_m = 1'b0;
        tw_m = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd_reg(15'h0000, 1'b0, v);
        chk(v, 16'h0000);
        chk({11'h000, cfg_o}, 16'h0000);
        wr_reg(15'h0000, 16'h0810, 1'b0);
        chk({11'h000, cfg_o}, 16'h0002);
        rd_reg(15'h0000, 1'b0, v);
        chk(v, 16'h0810);
        wr_reg(15'h0123, 16'hBEEF, 1'b0);
        chk(wd, 16'hBEEF);
        chk({1'b0, wa}, 16'h0123);
        rd_reg(15'h0123, 1'b0, v);
        chk(v, 16'h0123 ^ 16'h5A3C);
        wr_reg(15'h0000, 16'h8001, 1'b0);
        lsb_m = 1'b1;
        chk({11'h000, cfg_o}, 16'h0010);
        wr_reg(15'h0456, 16'h1234, 1'b0);
        chk(wd, 16'h1234);
        chk({1'b0, wa}, 16'h0456);
        rd_reg(15'h0000, 1'b0, v);
        chk(v, 16'h8001);
        wr_reg(15'h0000, 16'h4002, 1'b0);
        lsb_m = 1'b0;
        tw_m = 1'b1;
        chk({11'h000, cfg_o}, 16'h0008);
        rd_reg(15'h0123, 1'b0, v);
        chk(v, 16'h0123 ^ 16'h5A3C);
        wr_reg(15'h0000, 16'h1008, 1'b0);
        tw_m = 1'b0;
        chk({11'h000, cfg_o}, 16'h0004);
        wr_reg(15'h6010, 16'hC3A5, 1'b1);
        chk(wd, 16'hC3A5);
        rd_reg(15'h6020, 1'b1, v);
        chk(v, 16'h6020 ^ 16'h5A3C);
        rd_reg(15'h0123, 1'b0, v);
        chk(v, 16'h0123 ^ 16'h5A3C);
        wr_reg(15'h0000, 16'h0420, 1'b0);
        chk({11'h000, cfg_o}, 16'h0001);
        aux_dout <= 1'b1;
        repeat (3) @(posedge clk);
        chk({14'h0000, sdo_oe, sdo_o}, 16'h0003);
        aux_dout <= 1'b0;
        repeat (3) @(posedge clk);
        chk({14'h0000, sdo_oe, sdo_o}, 16'h0002);
        // Reset requested through the mirror copy alone
        wr_reg(15'h0000, 16'h0814, 1'b0);
        chk(mr_n[15:0], SWC[15:0]);
        rd_reg(15'h0000, 1'b0, v);
        chk(v, 16'h0810);
        chk({11'h000, cfg_o}, 16'h0002);
        chk(rd_n[15:0], 16'h0004);
        conclude();
    end
endmodule : testbench
`default_nettype wire
